//--- data_eeprom_access_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "dee_cfg.svh"
module data_eeprom_access_control_bench;
   localparam logic [11:0] o_ctl = `DEE_OFF_CTRL;
   localparam logic [11:0] o_ulk = `DEE_OFF_UNLOCK;
   localparam logic [11:0] o_adr = `DEE_OFF_ADDR;
   localparam logic [11:0] o_dat = `DEE_OFF_DATA;
   localparam logic [11:0] o_flg = `DEE_OFF_PFLAG;
   localparam logic [11:0] o_msk = `DEE_OFF_IMASK;
   logic        ref_clk = 1'b0;
   logic        resetn = 1'b0;
   logic        por_n = 1'b0;
   logic        ext_n = 1'b1;
   logic        wdt_n = 1'b1;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic [11:0] haddr = 12'h000;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        irq;
   logic        busy;
   integer      error_cnt = 0;
   integer      cmp_count = 0;
   integer      seed = 32'h402EC677;
   integer      i;
   logic [31:0] rd;
   logic [6:0]  a;
   logic [7:0]  d;

   always #50 ref_clk = ~ref_clk;

   dee_cell_model mdl_u ();

   dee_access dut_u (.REF_CLK(ref_clk), .RESETN(resetn), .POR_N(por_n),
      .EXT_RESET_PIN_N(ext_n), .WDT_RESET_N(wdt_n), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
      .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(),
      .IRQ(irq), .WRITE_BUSY(busy));

   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // One single AHB transfer, entered just after a rising edge
   task automatic xfer(input logic w, input logic [11:0] ad, input logic [31:0] wd);
      haddr <= ad;
      hwrite <= w;
      htrans <= 2'h2;
      hsel <= 1'b1;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic rdchk(input logic [11:0] ad, input logic [31:0] e);
      xfer(1'b0, ad, 32'h0);
      chk(rd, e);
   endtask

   task automatic start_wr(input logic [6:0] ad, input logic [7:0] dd);
      xfer(1'b1, o_adr, {25'h0, ad});
      xfer(1'b1, o_dat, {24'h0, dd});
      xfer(1'b1, o_ctl, 32'h04);
      xfer(1'b1, o_ulk, 32'h55);
      xfer(1'b1, o_ulk, 32'hAA);
      xfer(1'b1, o_ctl, 32'h06);
   endtask

   task automatic wait_done;
      integer n;
      n = 0;
      @(posedge ref_clk);
      while (busy === 1'b1 && n < 200) begin
         @(posedge ref_clk);
         n++;
      end
      chk({31'h0, n < 200}, 32'h1);
   endtask

   task automatic note(input integer n);
      $display("Test %0d finished", n);
   endtask

   initial begin
      repeat (16) @(posedge ref_clk);
      resetn <= 1'b1;
      por_n <= 1'b1;
      @(posedge ref_clk);
      rdchk(o_ctl, 32'h0);
      rdchk(o_ulk, 32'h0);
      xfer(1'b1, o_ctl, 32'hFC);
      rdchk(o_ctl, 32'h0C);
      xfer(1'b1, o_ulk, 32'h5A);
      rdchk(o_ulk, 32'h0);
      rdchk(o_ctl, 32'h0C);
      xfer(1'b1, o_ctl, 32'h0);
      rdchk(o_ctl, 32'h0);
      note(1);
      xfer(1'b1, o_msk, 32'h80);
      for (i = 0; i < 4; i++) begin
         a = 7'($random(seed));
         d = 8'($random(seed));
         start_wr(a, d);
         mdl_u.put(a, d);
         xfer(1'b1, o_ctl, 32'h0);
         rdchk(o_ctl, 32'h02);
         chk({31'h0, busy}, 32'h1);
         wait_done();
         rdchk(o_ctl, 32'h0);
         chk({31'h0, irq}, 32'h1);
         rdchk(o_flg, 32'h80);
         rdchk(o_flg, 32'h0);
         xfer(1'b1, o_ctl, 32'h01);
         rdchk(o_dat, {24'h0, mdl_u.mem[a]});
         rdchk(o_dat, {24'h0, mdl_u.mem[a]});
      end
      note(2);
      a = 7'($random(seed));
      xfer(1'b1, o_adr, {25'h0, a});
      xfer(1'b1, o_dat, {24'h0, ~mdl_u.mem[a]});
      xfer(1'b1, o_ulk, 32'h55);
      xfer(1'b1, o_ulk, 32'hAA);
      xfer(1'b1, o_ctl, 32'h02);
      rdchk(o_ctl, 32'h0);
      xfer(1'b1, o_ctl, 32'h04);
      xfer(1'b1, o_ulk, 32'hAA);
      xfer(1'b1, o_ulk, 32'h55);
      xfer(1'b1, o_ctl, 32'h06);
      rdchk(o_ctl, 32'h04);
      xfer(1'b1, o_ctl, 32'h01);
      rdchk(o_dat, {24'h0, mdl_u.mem[a]});
      note(3);
      xfer(1'b1, o_msk, 32'h0);
      start_wr(a, 8'h3C);
      mdl_u.put(a, 8'h3C);
      wait_done();
      rdchk(o_ctl, 32'h04);
      chk({31'h0, irq}, 32'h0);
      xfer(1'b1, o_msk, 32'h80);
      rdchk(o_msk, 32'h80);
      chk({31'h0, irq}, 32'h1);
      xfer(1'b1, o_flg, 32'h0);
      rdchk(o_flg, 32'h0);
      note(4);
      for (i = 0; i < 2; i++) begin
         a = 7'($random(seed));
         d = 8'($random(seed));
         start_wr(a, d);
         repeat (5) @(posedge ref_clk);
         if (i == 0) ext_n <= 1'b0;
         else wdt_n <= 1'b0;
         @(posedge ref_clk);
         ext_n <= 1'b1;
         wdt_n <= 1'b1;
         @(posedge ref_clk);
         rdchk(o_ctl, 32'h08);
         rdchk(o_adr, {25'h0, a});
         rdchk(o_dat, {24'h0, d});
         xfer(1'b1, o_ctl, 32'h0);
      end
      note(5);
      wrap_up();
   end

   initial begin
      #(100 * 30000);
      error_cnt++;
      wrap_up();
   end
endmodule
`default_nettype wire

//--- dee_access.sv
`timescale 1ns/1ps
`default_nettype none
`include "dee_cfg.svh"
// Overview of operation
// - Control bits seven to four read zero
// - Read trigger reads, write trigger writes
// - Software only sets both trigger bits
// - Hardware clears triggers on completion
// - Writes need write permit, readable writable
// - Power-up reset clears write permit
// - Pin or watchdog reset aborts write, flags
// - Address and data survive aborting reset
// - Write done flag set, software clears
// - Unlock port stores nothing, reads zero
// - Unlock port only arms write sequence
// - Read data appears next cycle
// - Data register holds until read/write
// - 55h then AAh then write trigger
// - Write trigger needs permit; clear later harmless
// - Seven address bits select 128 bytes
module dee_access
   import dee_pkg::*;
(
   input  wire logic        REF_CLK,
   input  wire logic        RESETN,
   input  wire logic        POR_N,
   input  wire logic        EXT_RESET_PIN_N,
   input  wire logic        WDT_RESET_N,
   input  wire logic        HSEL,
   input  wire logic [11:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic      [31:0] HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   output logic             IRQ,
   output logic             WRITE_BUSY
);
   // Whole-device reset; POR/pin/watchdog distinguish the cause
   logic        rst_n;
   assign rst_n = RESETN & POR_N & EXT_RESET_PIN_N & WDT_RESET_N;

   logic        ph_valid;
   logic        ph_write;
   logic [11:0] ph_addr;
   logic        next_ph_valid;
   logic        next_ph_write;
   logic [11:0] next_ph_addr;

   logic [7:0]  data_reg;
   logic [6:0]  addr_reg;
   logic        addr_b7;
   logic        rd_bit;
   logic        wr_bit;
   logic        write_permit;
   logic        write_abort_flag;
   logic        done_flag;
   logic        done_mask;
   logic        wr_live;
   logic        abort_rst;
   dee_unlock_t ul;
   dee_wstate_t ws;
   logic [`DEE_CNT_W-1:0] cnt;

   logic [7:0]  next_data_reg;
   logic [6:0]  next_addr_reg;
   logic        next_addr_b7;
   logic        next_rd_bit;
   logic        next_wr_bit;
   logic        next_write_permit;
   logic        next_write_abort_flag;
   logic        next_done_flag;
   logic        next_done_mask;
   dee_unlock_t next_ul;
   dee_wstate_t next_ws;
   logic [`DEE_CNT_W-1:0] next_cnt;
   logic [31:0] next_hrdata;

   logic [7:0]  cell_rdata;
   logic        cell_we;
   logic        wr_acc;
   logic        rd_acc;
   logic        wr_done;

   dee_cell_array u_cells (
      .clk   (REF_CLK),
      .rst_n (POR_N),
      .wr_en (cell_we),
      .addr  (addr_reg),
      .wdata (data_reg),
      .rdata (cell_rdata)
   );

   // Address phase capture
   always_comb begin
      next_ph_valid = HSEL & HREADY & HTRANS[1];
      next_ph_write = HWRITE;
      next_ph_addr  = HADDR;
   end

   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         ph_valid <= 1'b0;
         ph_write <= 1'b0;
         ph_addr  <= 12'h000;
      end else begin
         ph_valid <= next_ph_valid;
         ph_write <= next_ph_write;
         ph_addr  <= next_ph_addr;
      end
   end

   assign wr_acc  = ph_valid & ph_write;
   assign rd_acc  = next_ph_valid & ~HWRITE;
   assign wr_done = (ws == DEE_WR_BUSY) && (cnt == `DEE_CNT_W'(`DEE_WRITE_CYC - 1));
   assign cell_we = wr_done;
   assign abort_rst = ~(EXT_RESET_PIN_N & WDT_RESET_N);

   always_comb begin
      next_data_reg  = data_reg;
      next_addr_reg  = addr_reg;
      next_addr_b7   = addr_b7;
      next_rd_bit    = 1'b0;
      next_wr_bit    = wr_bit;
      next_write_permit      = write_permit;
      next_write_abort_flag     = write_abort_flag;
      next_done_flag = done_flag;
      next_done_mask = done_mask;
      next_ul        = ul;
      next_ws        = ws;
      next_cnt       = cnt;
      if (rd_bit) begin
         next_data_reg = cell_rdata;
      end
      if (ws == DEE_WR_BUSY) begin
         next_cnt = cnt + `DEE_CNT_W'(1);
         if (wr_done) begin
            next_ws     = DEE_WR_IDLE;
            next_wr_bit = 1'b0;
            next_cnt    = '0;
         end
      end
      // Read clears done flag; a set in the same cycle wins
      if (rd_acc && HADDR == `DEE_OFF_PFLAG) begin
         next_done_flag = 1'b0;
      end
      if (wr_acc) begin
         if (ph_addr != `DEE_OFF_UNLOCK && ph_addr != `DEE_OFF_CTRL) begin
            next_ul = DEE_UL_IDLE;
         end
         unique case (ph_addr)
            `DEE_OFF_DATA: begin
               if (ws == DEE_WR_IDLE) next_data_reg = HWDATA[7:0];
            end
            `DEE_OFF_ADDR: begin
               if (ws == DEE_WR_IDLE) begin
                  next_addr_reg = HWDATA[6:0];
                  next_addr_b7  = HWDATA[7];
               end
            end
            `DEE_OFF_UNLOCK: begin
               // No storage, only sequence state
               if (HWDATA[7:0] == `DEE_KEY1) next_ul = DEE_UL_KEY1;
               else if (HWDATA[7:0] == `DEE_KEY2 && ul == DEE_UL_KEY1) next_ul = DEE_UL_ARMED;
               else next_ul = DEE_UL_IDLE;
            end
            `DEE_OFF_CTRL: begin
               next_write_permit  = HWDATA[`DEE_CTRL_WRITE_PERMIT];
               next_write_abort_flag = HWDATA[`DEE_CTRL_WRITE_ABORT_FLAG];
               next_ul    = DEE_UL_IDLE;
               if (HWDATA[`DEE_CTRL_RD] && ws == DEE_WR_IDLE) begin
                  next_rd_bit = 1'b1;
               end
               if (HWDATA[`DEE_CTRL_WR] && write_permit && ul == DEE_UL_ARMED
                   && ws == DEE_WR_IDLE) begin
                  next_wr_bit = 1'b1;
                  next_ws     = DEE_WR_BUSY;
                  next_cnt    = '0;
               end
            end
            `DEE_OFF_PFLAG: begin
               if (!HWDATA[`DEE_PF_DONE]) next_done_flag = 1'b0;
            end
            `DEE_OFF_IMASK: next_done_mask = HWDATA[`DEE_PF_DONE];
            default: ;
         endcase
      end
      if (wr_done) begin
         next_done_flag = 1'b1;
      end
   end

   // Survives pin and watchdog resets
   always_ff @(posedge REF_CLK or negedge POR_N) begin
      if (!POR_N) begin
         data_reg <= 8'h00;
         addr_reg <= 7'h00;
         addr_b7  <= 1'b0;
         write_abort_flag    <= 1'b0;
         wr_live  <= 1'b0;
      end else begin
         data_reg <= next_data_reg;
         addr_reg <= next_addr_reg;
         addr_b7  <= next_addr_b7;
         // Write state is already cleared by the reset; use the tracked copy
         if (!rst_n) begin
            if (wr_live && abort_rst) write_abort_flag <= 1'b1;
            wr_live <= 1'b0;
         end else begin
            write_abort_flag   <= next_write_abort_flag;
            wr_live <= next_ws == DEE_WR_BUSY;
         end
      end
   end

   // Control state below is reset by rst_n; the abort cause is sampled in the block above
   always_ff @(posedge REF_CLK or negedge rst_n) begin
      if (!rst_n) begin
         rd_bit    <= 1'b0;
         wr_bit    <= 1'b0;
         write_permit      <= 1'b0;
         done_flag <= 1'b0;
         done_mask <= 1'b0;
         ul        <= DEE_UL_IDLE;
         ws        <= DEE_WR_IDLE;
         cnt       <= '0;
      end else begin
         rd_bit    <= next_rd_bit;
         wr_bit    <= next_wr_bit;
         write_permit      <= next_write_permit;
         done_flag <= next_done_flag;
         done_mask <= next_done_mask;
         ul        <= next_ul;
         ws        <= next_ws;
         cnt       <= next_cnt;
      end
   end

   // Read data mux registered for the data phase
   always_comb begin
      next_hrdata = 32'h0000_0000;
      if (rd_acc) begin
         unique case (HADDR)
            `DEE_OFF_DATA:   next_hrdata[7:0] = next_data_reg;
            `DEE_OFF_ADDR:   next_hrdata[7:0] = {addr_b7, addr_reg};
            `DEE_OFF_CTRL:   next_hrdata[`DEE_CTRL_W-1:0] = {write_abort_flag, write_permit, wr_bit, rd_bit};
            `DEE_OFF_UNLOCK: next_hrdata = 32'h0000_0000;
            `DEE_OFF_PFLAG:  next_hrdata[`DEE_PF_DONE] = done_flag;
            `DEE_OFF_IMASK:  next_hrdata[`DEE_PF_DONE] = done_mask;
            default:         next_hrdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         HRDATA     <= 32'h0000_0000;
         HREADYOUT  <= 1'b1;
         HRESP      <= 1'b0;
         IRQ        <= 1'b0;
         WRITE_BUSY <= 1'b0;
      end else begin
         HRDATA     <= next_hrdata;
         HREADYOUT  <= 1'b1;
         HRESP      <= 1'b0;
         IRQ        <= next_done_flag & next_done_mask;
         WRITE_BUSY <= next_ws == DEE_WR_BUSY;
      end
   end

   a_rd_self_clear: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      rd_bit |=> !rd_bit) else $error("read trigger stuck");
   a_rd_next_data: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      rd_bit |=> data_reg == $past(cell_rdata)) else $error("read data late");
   a_wr_needs_key: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      $rose(wr_bit) |-> $past(ul) == DEE_UL_ARMED && $past(write_permit))
      else $error("write without unlock");
   a_wr_done_flag: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      wr_done |=> !wr_bit && done_flag) else $error("write end wrong");
   a_wr_stays: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      wr_bit && !wr_done |=> wr_bit) else $error("write dropped");
   a_wr_length: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      $rose(wr_bit) |-> ##[1:100] wr_done) else $error("write too long");
   a_done_sticky: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      done_flag && !wr_acc && !(rd_acc && HADDR == `DEE_OFF_PFLAG) |=> done_flag)
      else $error("done flag lost");
   a_irq_level: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      ##1 IRQ == (done_flag & done_mask)) else $error("irq mismatch");
   a_addr_hold: assert property (@(posedge REF_CLK) disable iff (!rst_n)
      ws == DEE_WR_BUSY |=> $stable(addr_reg)) else $error("address moved");
   c_read: cover property (@(posedge REF_CLK) rd_bit);
   c_write: cover property (@(posedge REF_CLK) wr_done);
   c_abort: cover property (@(posedge REF_CLK) $rose(write_abort_flag));
endmodule
`default_nettype wire

//--- dee_cell_array.sv
`timescale 1ns/1ps
`default_nettype none
module dee_cell_array (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       wr_en,
   input  wire logic [6:0] addr,
   input  wire logic [7:0] wdata,
   output logic      [7:0] rdata
);
   logic [7:0] mem [0:127];
   logic [7:0] next_mem [0:127];

   always_comb begin
      for (int i = 0; i < 128; i++) begin
         next_mem[i] = mem[i];
      end
      if (wr_en) begin
         next_mem[addr] = wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 128; i++) begin
            mem[i] <= 8'hFF;
         end
      end else begin
         for (int i = 0; i < 128; i++) begin
            mem[i] <= next_mem[i];
         end
      end
   end

   assign rdata = mem[addr];
endmodule
`default_nettype wire

//--- dee_cell_model.sv
`timescale 1ns/1ps
`default_nettype none
module dee_cell_model;
   logic [7:0] mem [128];
   initial begin
      foreach (mem[k]) mem[k] = 8'hFF;
   end
   // Seven address bits pick one byte
   task automatic put(input logic [6:0] a, input logic [7:0] d);
      mem[a] = d;
   endtask
endmodule
`default_nettype wire

//--- dee_cfg.svh
`ifndef DEE_CFG_SVH
`define DEE_CFG_SVH

// Byte addresses (printed offsets are multiples of four where given)
`define DEE_OFF_DATA      12'h098
`define DEE_OFF_ADDR      12'h094
`define DEE_OFF_CTRL      12'h09C
`define DEE_OFF_UNLOCK    12'h0A0
`define DEE_OFF_PFLAG     12'h0A4
`define DEE_OFF_IMASK     12'h0A8

// Control register fields
`define DEE_CTRL_RD       0
`define DEE_CTRL_WR       1
`define DEE_CTRL_WRITE_PERMIT     2
`define DEE_CTRL_WRITE_ABORT_FLAG    3
`define DEE_CTRL_W        4

// Peripheral flag fields
`define DEE_PF_DONE       7

// Unlock codes
`define DEE_KEY1          8'h55
`define DEE_KEY2          8'hAA

// Write cell time
`define DEE_WRITE_NS      4000
`define DEE_CLK_NS        100
`define DEE_WRITE_CYC     ((`DEE_WRITE_NS + `DEE_CLK_NS - 1) / `DEE_CLK_NS)
`define DEE_CNT_W         16

`endif

//--- dee_pkg.sv
package dee_pkg;
   typedef enum logic [1:0] {DEE_UL_IDLE, DEE_UL_KEY1, DEE_UL_ARMED} dee_unlock_t;
   typedef enum logic {DEE_WR_IDLE, DEE_WR_BUSY} dee_wstate_t;
endpackage
